//--- design/fault_flag_pkg.sv
`default_nettype none
package fault_flag_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 5;
    localparam int RAW_W = 8;

    // register indices; the byte address on the bus is four times the index
    localparam logic [9:0] SUMMARY_IDX = 10'h2c0;
    localparam logic [9:0] FLAG_IDX = 10'h2c1;
    localparam logic [9:0] HIDE_IDX = 10'h2c2;
    localparam logic [9:0] PIN_SEL_IDX = 10'h2c3;
    localparam logic [ADDR_W-1:0] SUMMARY_ADDR = {SUMMARY_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] FLAG_ADDR = {FLAG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] HIDE_ADDR = {HIDE_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] PIN_SEL_ADDR = {PIN_SEL_IDX, 2'h0};

    localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h1f;
    localparam logic [FLAG_W-1:0] HIDE_RESET = 5'h1f;
    localparam logic PIN_SEL_RESET = 1'h0;
    localparam logic [RAW_W-1:0] RAW_RESET = 8'h00;

    // bit order follows the register: bit 4 down to bit 0
    typedef struct packed {
        logic pll_unlock_flag;
        logic link_down_flag;
        logic clock_realign_flag;
        logic oscillator_upset_flag;
        logic divider_mismatch_flag;
    } fault_bits_t;

    typedef struct packed {
        logic hide_pll_unlock;
        logic hide_link_down;
        logic hide_clock_realign;
        logic hide_oscillator_upset;
        logic hide_divider_mismatch;
    } hide_bits_t;

    // raw inputs from the detectors, gathered for the synchroniser bank
    typedef struct packed {
        logic cal_status;
        logic pll_locked;
        logic serial_link_enable;
        logic link_data_state;
        logic clock_realign;
        logic nco_resync;
        logic phase_mismatch;
        logic divider_mismatch;
    } raw_in_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage
`default_nettype wire

//--- design/level_sync_bank.sv
`timescale 1ns/100ps
`default_nettype none
module level_sync_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] stable_ff;
    logic [WIDTH-1:0] nxt_stable;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // a change is taken only once stages two and three agree
            always_comb
            begin
                nxt_stable[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] :
                    stable_ff[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            stable_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= async_in;
            s2_ff <= meta_ff;
            s3_ff <= s2_ff;
            stable_ff <= nxt_stable;
        end
    end

    assign stable_out = stable_ff;

endmodule // level_sync_bank
`default_nettype wire

//--- design/fault_flag_aggregator.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - summary bit is high while any flag is set with its mask clear.
// - a set mask bit 4..0 keeps the same flag out of the summary.
// - when selected, the summary drives the status output pin as interrupt.
// - flag bit 4 sets whenever the PLL is not locked.
// - flag bit 3 sets while the link is enabled but not in data state.
// - flag bit 2 sets whenever a realign event realigns internal clocks.
// - flag bit 1 sets on NCO disable, NCO resync or phase mismatch.
// - flag bit 0 sets whenever channel A and B dividers disagree.
// - writing one clears that flag only; other flags are untouched.
// - the flag register resets to 0x1f, all flags set.
// - the mask register resets to 0x1f, all flags masked.
// - the summary register is read-only; upper 31 bits reserved.
module fault_flag_aggregator
    import fault_flag_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic pll_locked_in,
    input wire logic serial_link_enable_in,
    input wire logic link_data_state_in,
    input wire logic clock_realign_in,
    input wire logic nco_resync_in,
    input wire logic phase_mismatch_in,
    input wire logic divider_mismatch_in,
    input wire logic cal_status_in,
    output logic status_output_pin_out,
    output logic irq_out
);

    logic rst_meta_ff;
    logic rst_n_ff;
    raw_in_t raw_async;
    raw_in_t raw_sync;
    fault_bits_t cond;
    fault_bits_t flags_ff;
    fault_bits_t nxt_flags;
    hide_bits_t hide_ff;
    hide_bits_t nxt_hide;
    logic pin_sel_ff;
    logic nxt_pin_sel;
    bus_state_t state_ff;
    bus_state_t nxt_state;
    logic [DATA_W-1:0] readdata_ff;
    logic [DATA_W-1:0] nxt_readdata;
    logic wr_take;
    logic lane0;
    logic [FLAG_W-1:0] clr_vec;
    logic summary;

    // release of the reset is synchronised; assertion stays asynchronous
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // detector levels arrive from other clock domains
    assign raw_async = '{
        cal_status: cal_status_in,
        pll_locked: pll_locked_in,
        serial_link_enable: serial_link_enable_in,
        link_data_state: link_data_state_in,
        clock_realign: clock_realign_in,
        nco_resync: nco_resync_in,
        phase_mismatch: phase_mismatch_in,
        divider_mismatch: divider_mismatch_in
    };

    level_sync_bank #(
        .WIDTH(RAW_W),
        .RESET_VAL(RAW_RESET)
    ) u_sync (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_ff),
        .async_in(raw_async),
        .stable_out(raw_sync)
    );

    always_comb
    begin
        cond.pll_unlock_flag = !raw_sync.pll_locked;
        cond.link_down_flag = raw_sync.serial_link_enable &&
            !raw_sync.link_data_state;
        cond.clock_realign_flag = raw_sync.clock_realign;
        // a cleared link enable also stops the NCOs
        cond.oscillator_upset_flag = !raw_sync.serial_link_enable ||
            raw_sync.nco_resync || raw_sync.phase_mismatch;
        cond.divider_mismatch_flag = raw_sync.divider_mismatch;
    end

    // bus handshake: every request waits one cycle, then is answered
    always_comb
    begin
        nxt_state = state_ff;
        nxt_readdata = readdata_ff;
        case (state_ff)
            BUS_IDLE:
            begin
                if (avs_read_in || avs_write_in)
                begin
                    nxt_state = BUS_ANSWER;
                end
                if (avs_read_in)
                begin
                    case (avs_address_in)
                        SUMMARY_ADDR: nxt_readdata =
                            DATA_W'(summary);
                        FLAG_ADDR: nxt_readdata = DATA_W'(flags_ff);
                        HIDE_ADDR: nxt_readdata = DATA_W'(hide_ff);
                        PIN_SEL_ADDR: nxt_readdata = DATA_W'(pin_sel_ff);
                        default: nxt_readdata = '0;
                    endcase
                end
            end
            BUS_ANSWER:
            begin
                nxt_state = BUS_IDLE;
            end
            default:
            begin
                nxt_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff <= BUS_IDLE;
            readdata_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            readdata_ff <= nxt_readdata;
        end
    end

    assign avs_waitrequest_out = (avs_read_in || avs_write_in) &&
        (state_ff != BUS_ANSWER);
    assign avs_readdata_out = readdata_ff;

    // a write lands at the edge where waitrequest is seen low
    assign wr_take = avs_write_in && (state_ff == BUS_ANSWER);
    assign lane0 = avs_byteenable_in[0];
    assign clr_vec = (wr_take && lane0 && avs_address_in == FLAG_ADDR) ?
        avs_writedata_in[FLAG_W-1:0] : '0;

    always_comb
    begin
        // set beats clear, so a persisting fault is never lost
        nxt_flags = (flags_ff & ~clr_vec) | cond;
        nxt_hide = hide_ff;
        nxt_pin_sel = pin_sel_ff;
        if (wr_take && lane0 && avs_address_in == HIDE_ADDR)
        begin
            nxt_hide = avs_writedata_in[FLAG_W-1:0];
        end
        if (wr_take && lane0 && avs_address_in == PIN_SEL_ADDR)
        begin
            nxt_pin_sel = avs_writedata_in[0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            flags_ff <= FLAG_RESET;
            hide_ff <= HIDE_RESET;
            pin_sel_ff <= PIN_SEL_RESET;
        end
        else
        begin
            flags_ff <= nxt_flags;
            hide_ff <= nxt_hide;
            pin_sel_ff <= nxt_pin_sel;
        end
    end

    assign summary = |(flags_ff & ~hide_ff);
    assign irq_out = summary;
    // unselected, the pin keeps showing calibration status
    assign status_output_pin_out = pin_sel_ff ? summary :
        raw_sync.cal_status;

    a_summary_level: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        (flags_ff.pll_unlock_flag && !hide_ff.hide_pll_unlock) ||
        (flags_ff.link_down_flag && !hide_ff.hide_link_down) ||
        (flags_ff.clock_realign_flag && !hide_ff.hide_clock_realign) ||
        (flags_ff.oscillator_upset_flag &&
        !hide_ff.hide_oscillator_upset) ||
        (flags_ff.divider_mismatch_flag && !hide_ff.hide_divider_mismatch)
        |-> irq_out)
        else $error("summary low with an unmasked flag set");

    a_mask_blocks: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        ((flags_ff & ~hide_ff) == 5'h00) |-> !irq_out)
        else $error("masked flag reached the summary");

    a_pin_route: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        pin_sel_ff |-> (status_output_pin_out == irq_out))
        else $error("status pin not showing summary when selected");

    a_pll_sets: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        !raw_sync.pll_locked |=> flags_ff.pll_unlock_flag)
        else $error("pll unlock flag not set");

    a_link_sets: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        raw_sync.serial_link_enable && !raw_sync.link_data_state
        |=> flags_ff.link_down_flag)
        else $error("link down flag not set");

    a_realign_sets: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        $rose(raw_sync.clock_realign) |=> flags_ff.clock_realign_flag)
        else $error("realign flag not set");

    a_upset_sets: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        !raw_sync.serial_link_enable || raw_sync.nco_resync ||
        raw_sync.phase_mismatch |=> flags_ff.oscillator_upset_flag)
        else $error("oscillator upset flag not set");

    a_divider_sets: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        raw_sync.divider_mismatch |=> flags_ff.divider_mismatch_flag)
        else $error("divider mismatch flag not set");

    a_clear_exact: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        wr_take && lane0 && avs_address_in == FLAG_ADDR |=>
        (($past(flags_ff) & ~$past(avs_writedata_in[FLAG_W-1:0]) &
        ~flags_ff) == '0))
        else $error("flag clear touched the wrong bits");

    a_clear_lands: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        wr_take && lane0 && avs_address_in == FLAG_ADDR |=>
        ((flags_ff & $past(avs_writedata_in[FLAG_W-1:0]) & ~$past(cond)) ==
        '0))
        else $error("written flag not cleared");

    a_flag_sticky: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        !(wr_take && lane0 && avs_address_in == FLAG_ADDR) |=>
        (($past(flags_ff) & ~flags_ff) == '0))
        else $error("flag dropped without a clear");

    a_hide_write: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        wr_take && lane0 && avs_address_in == HIDE_ADDR |=>
        hide_ff == $past(avs_writedata_in[FLAG_W-1:0]))
        else $error("mask write did not land");

    a_reset_values: assert property (
        @(posedge mclk_in)
        $rose(rst_n_ff) |-> (flags_ff == FLAG_RESET) &&
        (hide_ff == HIDE_RESET))
        else $error("flag or mask register reset value wrong");

    a_summary_ro: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        wr_take && avs_address_in == SUMMARY_ADDR |=>
        $stable(hide_ff) && $stable(pin_sel_ff))
        else $error("write to summary register changed state");

    a_summary_upper: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        avs_read_in && !avs_waitrequest_out &&
        avs_address_in == SUMMARY_ADDR |->
        avs_readdata_out[DATA_W-1:1] == '0)
        else $error("reserved summary bits not zero");

    a_bus_answer: assert property (
        @(posedge mclk_in) disable iff (!rst_n_ff)
        avs_waitrequest_out &&
        (avs_read_in || avs_write_in) ##1 (avs_read_in || avs_write_in)
        |-> !avs_waitrequest_out)
        else $error("request not answered after one wait cycle");

endmodule // fault_flag_aggregator
`default_nettype wire

//--- verif/fault_flag_aggregator_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fault_flag_aggregator_tb_top import fault_flag_pkg::*;;
    logic mclk, nrst, rd, wr, cal, pin, irq, wreq;
    logic lock, en, dstate, realign, resync, phase, div;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, q, e;
    logic [3:0] be;
    logic [11:0] rows [7];
    int num_errors, checks, cycles;

    fault_flag_aggregator uut (
        .mclk_in(mclk), .nrst_in(nrst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .pll_locked_in(lock),
        .serial_link_enable_in(en), .link_data_state_in(dstate),
        .clock_realign_in(realign), .nco_resync_in(resync),
        .phase_mismatch_in(phase), .divider_mismatch_in(div),
        .cal_status_in(cal), .status_output_pin_out(pin), .irq_out(irq)
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one edge between transfers so a strobe is never driven twice at once
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= d;
        do @(posedge mclk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] exp);
        xfer(1'b0, a, '0);
        chk(q, exp);
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        nrst = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
        be = 4'hf;
        cal = 1'b0;
        {lock, en, dstate, realign, resync, phase, div} = 7'h70;
        num_errors = 0;
        checks = 0;
        cycles = 0;
        // detector levels {lock,en,data,realign,resync,phase,div}, flag
        rows = '{12'h610, 12'hc08, 12'hf04, 12'ha02, 12'he82, 12'he42,
            12'he21};
        wt(20);
        nrst <= 1'b1;
        wt(3);
        rchk(FLAG_ADDR, 32'h1f);
        rchk(HIDE_ADDR, 32'h1f);
        rchk(SUMMARY_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wt(8);
        xfer(1'b1, FLAG_ADDR, 32'h1f);
        rchk(FLAG_ADDR, 32'h0);
        xfer(1'b1, HIDE_ADDR, 32'h0);
        rchk(HIDE_ADDR, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            e = {27'h0, rows[i][4:0]};
            @(posedge mclk);
            {lock, en, dstate, realign, resync, phase, div} <= rows[i][11:5];
            wt(8);
            chk({31'h0, irq}, 32'h1);
            {lock, en, dstate, realign, resync, phase, div} <= 7'h70;
            wt(8);
            rchk(FLAG_ADDR, e);
            rchk(SUMMARY_ADDR, 32'h1);
            xfer(1'b1, HIDE_ADDR, e);
            rchk(SUMMARY_ADDR, 32'h0);
            chk({31'h0, irq}, 32'h0);
            xfer(1'b1, HIDE_ADDR, 32'h0);
            xfer(1'b1, FLAG_ADDR, ~e & 32'h1f);
            rchk(FLAG_ADDR, e);
            xfer(1'b1, FLAG_ADDR, e);
            rchk(FLAG_ADDR, 32'h0);
        end
        // a clear while the cause persists must not stick
        lock <= 1'b0;
        wt(8);
        xfer(1'b1, FLAG_ADDR, 32'h10);
        rchk(FLAG_ADDR, 32'h10);
        lock <= 1'b1;
        wt(8);
        xfer(1'b1, FLAG_ADDR, 32'h10);
        rchk(FLAG_ADDR, 32'h0);
        xfer(1'b1, SUMMARY_ADDR, 32'hffffffff);
        rchk(SUMMARY_ADDR, 32'h0);
        rchk(FLAG_ADDR, 32'h0);
        be <= 4'h0;
        xfer(1'b1, HIDE_ADDR, 32'h1f);
        be <= 4'hf;
        rchk(HIDE_ADDR, 32'h0);
        xfer(1'b1, 12'hb10, 32'hff);
        rchk(12'hb10, 32'h0);
        cal <= 1'b1;
        wt(6);
        chk({31'h0, pin}, 32'h1);
        xfer(1'b1, PIN_SEL_ADDR, 32'h1);
        // the select lands at the edge the transfer ends on
        wt(1);
        chk({31'h0, pin}, 32'h0);
        rchk(PIN_SEL_ADDR, 32'h1);
        lock <= 1'b0;
        wt(8);
        chk({31'h0, pin}, 32'h1);
        xfer(1'b1, HIDE_ADDR, 32'h10);
        wt(1);
        chk({31'h0, pin}, 32'h0);
        lock <= 1'b1;
        nrst <= 1'b0;
        wt(2);
        nrst <= 1'b1;
        wt(3);
        rchk(FLAG_ADDR, 32'h1f);
        rchk(HIDE_ADDR, 32'h1f);
        chk({31'h0, irq}, 32'h0);
        wrap_up();
    end
endmodule // fault_flag_aggregator_tb_top
`default_nettype wire
